// *** logic/pmucc_regs.svh ***
// Register indices, field positions, reset values and counts of the power-management clock control
`ifndef PMUCC_REGS_SVH
`define PMUCC_REGS_SVH
// Word index on the bus; the byte address is four times the index
`define PMUCC_IDX_CLKSEL 10'h0ad
`define PMUCC_IDX_RSVD 10'h0ae
`define PMUCC_IDX_UNIT 10'h0af
`define PMUCC_IDX_STAT 10'h0c0
`define PMUCC_IDX_CLR 10'h0c1
`define PMUCC_IDX_IEN 10'h0c2
`define PMUCC_RST_CLKSEL 8'h00
`define PMUCC_RST_UNIT 8'h00
`define PMUCC_RST_IRQ 3'h0
`define PMUCC_RSVD_VALUE 8'h00
// Clock-select control fields
`define PMUCC_B_TMRMGMT 6
`define PMUCC_B_ACEN 4
`define PMUCC_B_KBDEN 3
`define PMUCC_B_MAIN_PLL_OFF_IN_LOW_SPEED 2
`define PMUCC_B_LSSEL_HI 1
`define PMUCC_B_LSSEL_LO 0
// Timer-unit control fields
`define PMUCC_B_DZUNIT 7
`define PMUCC_B_LSUNIT 6
`define PMUCC_B_BLFORCE 5
`define PMUCC_B_DZEXT 0
// Bits of neighbouring registers seen as inputs
`define PMUCC_B_MWB_EXT 3
`define PMUCC_B_ACMASK 6
// Status bit positions
`define PMUCC_S_AC 0
`define PMUCC_S_TMR 1
`define PMUCC_S_BL 2
`define PMUCC_DZEXT_REFRESH 7'h40
`define PMUCC_KBD_PORT 16'h0060
`endif

// *** logic/pmucc_pkg.sv ***
// Types shared by the power-management clock control
package pmucc_pkg;
  typedef enum logic [2:0] {
    PMUCC_HS, PMUCC_LS, PMUCC_DOZE, PMUCC_SLEEP, PMUCC_SUSP
  } pmucc_mode_t;
  // CPU clock choice: low_pll set selects the low-speed PLL, div halves it div times
  typedef struct packed {
    logic low_pll;
    logic [1:0] div;
  } pmucc_clk_t;
  typedef enum logic {PMUCC_DX_IDLE, PMUCC_DX_RUN} pmucc_dx_t;
endpackage : pmucc_pkg

// *** logic/pmucc_top.sv ***
// Power-management clock and control registers with Wishbone slave
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/10ps
`include "pmucc_regs.svh"

// Function
// - Timer-to-management enable steers timer channel 0 to the management interrupt.
// - AC-input activity enable makes AC-present changes count as activity.
// - With AC activity disabled, the AC bit of the activity mask is ignored.
// - Keyboard enable releases keyboard select and clock pins when other conditions hold.
// - Keyboard enable decodes reads of port 60h internally.
// - Keyboard enable sources interrupt 1 from internal keyboard logic.
// - Main-PLL-off stops high-speed PLL in low-speed mode, else only Doze, Sleep and Suspend stop it.
// - Low-speed select gives 9.216, 4.608, 2.304 or 1.152 MHz.
// - Low-speed select acts only in low-speed PLL mode.
// - Doze timer unit bit: one is 1/4 s, zero is 1/16 s.
// - Low-speed timer unit bit: one is 1/16 s, zero is 1/512 s.
// - Battery-low force runs high-speed mode at low speed when battery and AC low.
// - Doze extension keeps CPU running 64 refresh cycles after timer interrupt 0.
// - Doze extension works only when memory window control bit 3 is set.
module pmucc_top import pmucc_pkg::*; (
  input wire logic clk_i, // 10 MHz clock
  input wire logic rst_i, // Synchronous reset
  input wire logic ce_i, // Clock enable
  input wire logic [11:0] adr_i, // Wishbone byte address
  input wire logic [31:0] dat_i, // Wishbone write data
  input wire logic [3:0] sel_i, // Wishbone byte selects
  input wire logic we_i, // Wishbone write
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  output logic [31:0] dat_o, // Wishbone read data
  output logic ack_o, // Wishbone acknowledge
  input wire pmucc_mode_t pmu_mode_i, // Current power mode
  input wire logic tmr0_irq_i, // Timer channel 0 request
  input wire logic refresh_i, // Refresh cycle pulse
  input wire logic [7:0] mwb_ctl_i, // Memory window control contents
  input wire logic [7:0] act_mask_i, // Activity mask contents
  input wire logic ac_present_input_i, // AC present pin
  input wire logic battery_low_1_input_i, // Battery low pin, low active
  input wire logic irq1_pin_i, // External interrupt 1 pin
  input wire logic kbd_int_irq_i, // Internal keyboard interrupt
  input wire logic kbd_other_ok_i, // Other release conditions met
  input wire logic io_rd_i, // I/O read strobe
  input wire logic [15:0] io_adr_i, // I/O address
  input wire logic kbd_cs_drv_i, // Value to drive on select pin
  input wire logic system_clock_pin_drv_i, // Value to drive on clock pin
  input wire logic keyboard_chip_select_pin_i, // Select pin level
  output logic keyboard_chip_select_pin_o, // Select pin drive
  output logic keyboard_chip_select_pin_oe_o, // Select pin enable
  input wire logic system_clock_pin_i, // Clock pin level
  output logic system_clock_pin_o, // Clock pin drive
  output logic system_clock_pin_oe_o, // Clock pin enable
  output logic [1:0] pin_sense_o, // Synced select and clock pin levels
  output logic timer_irq0_o, // Ordinary interrupt 0
  output logic mgmt_int_o, // Management interrupt from timer
  output logic activity_o, // AC activity pulse
  output logic port60_int_o, // Port 60h read served inside
  output logic irq1_o, // Interrupt 1 to controller
  output logic hs_pll_stop_o, // Stop high-speed PLL
  output pmucc_clk_t cpu_clk_o, // CPU clock choice
  output logic doze_unit_o, // Doze timer unit select
  output logic ls_unit_o, // Low-speed timer unit select
  output logic cpu_run_ext_o, // Doze run extension active
  output logic irq_o // Interrupt, high while enabled status set
);

  // ********************
  // Pin synchronisers
  // ********************
  logic [4:0] sy1;
  logic [4:0] sy2;
  logic ac_prev;
  logic tmr_prev;
  logic bl_prev;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sy1 <= 5'h00;
      sy2 <= 5'h00;
    end else if (ce_i) begin
      sy1 <= {system_clock_pin_i, keyboard_chip_select_pin_i, irq1_pin_i,
              battery_low_1_input_i, ac_present_input_i};
      sy2 <= sy1;
    end
  end

  wire ac_s = sy2[0];
  wire bl_n_s = sy2[1];
  wire irq1_s = sy2[2];

  // ********************
  // Register bus
  // ********************
  logic [7:0] clksel;
  logic [7:0] unit;
  logic [2:0] stat;
  logic [2:0] ien;
  logic [7:0] rd_val;
  wire wb_go = cyc_i & stb_i & ~ack_o;
  wire wr_lo = wb_go & we_i & sel_i[0];
  wire [9:0] widx = adr_i[11:2];

  always_comb begin
    case (widx)
      `PMUCC_IDX_CLKSEL: rd_val = clksel;
      `PMUCC_IDX_RSVD: rd_val = `PMUCC_RSVD_VALUE;
      `PMUCC_IDX_UNIT: rd_val = unit;
      `PMUCC_IDX_STAT: rd_val = {5'h00, stat};
      `PMUCC_IDX_IEN: rd_val = {5'h00, ien};
      default: rd_val = 8'h00;
    endcase
  end

  // Every address is answered one cycle after the request, unmapped ones with zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else if (ce_i) begin
      ack_o <= wb_go;
      if (wb_go && !we_i) begin
        dat_o <= {24'h0, rd_val};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clksel <= `PMUCC_RST_CLKSEL;
      unit <= `PMUCC_RST_UNIT;
      ien <= `PMUCC_RST_IRQ;
    end else if (ce_i && wr_lo) begin
      case (widx)
        `PMUCC_IDX_CLKSEL: clksel <= dat_i[7:0];
        `PMUCC_IDX_UNIT: unit <= dat_i[7:0];
        `PMUCC_IDX_IEN: ien <= dat_i[2:0];
        default: ;
      endcase
    end
  end

  wire tmr_en = clksel[`PMUCC_B_TMRMGMT];
  wire ac_en = clksel[`PMUCC_B_ACEN];
  wire kbd_en = clksel[`PMUCC_B_KBDEN];
  wire main_off = clksel[`PMUCC_B_MAIN_PLL_OFF_IN_LOW_SPEED];
  wire dz_ext = unit[`PMUCC_B_DZEXT];
  wire tmr_rise = tmr0_irq_i & ~tmr_prev;
  wire ac_chg = ac_s ^ ac_prev;
  wire in_ls = (pmu_mode_i == PMUCC_LS);
  wire bl_force = unit[`PMUCC_B_BLFORCE] & ~bl_n_s & ~ac_s & (pmu_mode_i == PMUCC_HS);

  // ********************
  // Event status
  // ********************
  logic [2:0] ev;
  logic [2:0] clr;
  // Enable write seen in its own cycle, so irq_o follows status and enable without a lag
  wire [2:0] ien_nx = (wr_lo && widx == `PMUCC_IDX_IEN) ? dat_i[2:0] : ien;
  always_comb begin
    ev = 3'h0;
    ev[`PMUCC_S_AC] = ac_chg & ac_en & act_mask_i[`PMUCC_B_ACMASK];
    ev[`PMUCC_S_TMR] = tmr_rise & tmr_en;
    ev[`PMUCC_S_BL] = bl_force & ~bl_prev;
    clr = (wr_lo && widx == `PMUCC_IDX_CLR) ? dat_i[2:0] : 3'h0;
  end

  // A new event beats a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat <= `PMUCC_RST_IRQ;
      irq_o <= 1'b0;
      ac_prev <= 1'b0;
      tmr_prev <= 1'b0;
      bl_prev <= 1'b0;
    end else if (ce_i) begin
      stat <= (stat & ~clr) | ev;
      irq_o <= |(((stat & ~clr) | ev) & ien_nx);
      ac_prev <= ac_s;
      tmr_prev <= tmr0_irq_i;
      bl_prev <= bl_force;
    end
  end

  // ********************
  // Interrupt and pin routing
  // ********************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_irq0_o <= 1'b0;
      mgmt_int_o <= 1'b0;
      activity_o <= 1'b0;
    end else if (ce_i) begin
      timer_irq0_o <= tmr0_irq_i & ~tmr_en;
      mgmt_int_o <= tmr0_irq_i & tmr_en;
      activity_o <= ev[`PMUCC_S_AC];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      keyboard_chip_select_pin_o <= 1'b0;
      keyboard_chip_select_pin_oe_o <= 1'b1;
      system_clock_pin_o <= 1'b0;
      system_clock_pin_oe_o <= 1'b1;
      pin_sense_o <= 2'h0;
      port60_int_o <= 1'b0;
      irq1_o <= 1'b0;
    end else if (ce_i) begin
      keyboard_chip_select_pin_o <= kbd_cs_drv_i;
      system_clock_pin_o <= system_clock_pin_drv_i;
      keyboard_chip_select_pin_oe_o <= ~(kbd_en & kbd_other_ok_i);
      system_clock_pin_oe_o <= ~(kbd_en & kbd_other_ok_i);
      pin_sense_o <= sy2[4:3];
      port60_int_o <= kbd_en & io_rd_i & (io_adr_i == `PMUCC_KBD_PORT);
      irq1_o <= kbd_en ? kbd_int_irq_i : irq1_s;
    end
  end

  // ********************
  // Clock control
  // ********************
  // Low-speed divisor is taken on entry, so a late change waits for the next entry
  logic [1:0] ls_div;
  logic ls_prev;
  wire ls_entry = in_ls & ~ls_prev;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ls_div <= 2'h0;
      ls_prev <= 1'b0;
      cpu_clk_o <= '0;
      hs_pll_stop_o <= 1'b0;
      doze_unit_o <= 1'b0;
      ls_unit_o <= 1'b0;
    end else if (ce_i) begin
      ls_prev <= in_ls;
      if (ls_entry) begin
        ls_div <= clksel[`PMUCC_B_LSSEL_HI:`PMUCC_B_LSSEL_LO];
      end
      cpu_clk_o.low_pll <= in_ls | bl_force;
      if (ls_entry) begin
        cpu_clk_o.div <= clksel[`PMUCC_B_LSSEL_HI:`PMUCC_B_LSSEL_LO];
      end else begin
        cpu_clk_o.div <= in_ls ? ls_div : 2'h0;
      end
      hs_pll_stop_o <= (in_ls & main_off) | (pmu_mode_i == PMUCC_DOZE)
                       | (pmu_mode_i == PMUCC_SLEEP) | (pmu_mode_i == PMUCC_SUSP);
      doze_unit_o <= unit[`PMUCC_B_DZUNIT];
      ls_unit_o <= unit[`PMUCC_B_LSUNIT];
    end
  end

  // ********************
  // Doze run extension
  // ********************
  pmucc_dx_t dx_state;
  pmucc_dx_t next_dx_state;
  logic [6:0] dx_cnt;
  logic [6:0] next_dx_cnt;
  wire in_doze = (pmu_mode_i == PMUCC_DOZE);
  wire dx_trig = tmr_rise & in_doze & dz_ext & mwb_ctl_i[`PMUCC_B_MWB_EXT];

  always_comb begin
    next_dx_state = dx_state;
    next_dx_cnt = dx_cnt;
    case (dx_state)
      PMUCC_DX_IDLE: begin
        if (dx_trig) begin
          next_dx_state = PMUCC_DX_RUN;
          next_dx_cnt = `PMUCC_DZEXT_REFRESH;
        end
      end
      PMUCC_DX_RUN: begin
        if (!in_doze) begin
          next_dx_state = PMUCC_DX_IDLE;
        end else if (dx_trig) begin
          next_dx_cnt = `PMUCC_DZEXT_REFRESH;
        end else if (refresh_i) begin
          next_dx_cnt = dx_cnt - 7'h01;
          if (dx_cnt == 7'h01) begin
            next_dx_state = PMUCC_DX_IDLE;
          end
        end
      end
      default: next_dx_state = PMUCC_DX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dx_state <= PMUCC_DX_IDLE;
      dx_cnt <= 7'h00;
      cpu_run_ext_o <= 1'b0;
    end else if (ce_i) begin
      dx_state <= next_dx_state;
      dx_cnt <= next_dx_cnt;
      cpu_run_ext_o <= (next_dx_state == PMUCC_DX_RUN);
    end
  end

  // ********************
  // Assertions
  // ********************
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_dx_start;
    ce_i && dx_trig;
  endsequence

  sequence s_dx_last;
    ce_i && dx_state == PMUCC_DX_RUN && in_doze && !dx_trig && refresh_i && dx_cnt == 7'h01;
  endsequence

  AST_TMR_MGMT: assert property (ce_i && tmr0_irq_i && tmr_en |=> mgmt_int_o && !timer_irq0_o)
    else $error("timer request not steered to management interrupt");
  AST_AC_ACT: assert property (ce_i && ac_en && act_mask_i[6] && ac_chg |=> activity_o)
    else $error("AC change not seen as activity");
  AST_AC_OFF: assert property (ce_i && !ac_en |=> !activity_o)
    else $error("activity while AC enable clear");
  AST_PIN_REL: assert property (ce_i && kbd_en && kbd_other_ok_i |=> !keyboard_chip_select_pin_oe_o)
    else $error("select pin still driven");
  AST_PORT60: assert property (ce_i && !kbd_en |=> !port60_int_o)
    else $error("port decode without keyboard enable");
  AST_IRQ1: assert property (ce_i && kbd_en |=> irq1_o == $past(kbd_int_irq_i))
    else $error("interrupt 1 not from internal logic");
  AST_PLL_LS: assert property (ce_i && in_ls && !main_off |=> !hs_pll_stop_o)
    else $error("PLL stopped in low-speed mode");
  AST_DIV_HS: assert property (ce_i && !in_ls |=> cpu_clk_o.div == 2'h0)
    else $error("divisor applied outside low-speed mode");
  AST_BL_FORCE: assert property (ce_i && bl_force |=> cpu_clk_o.low_pll)
    else $error("battery force ignored");
  AST_DX_RUN: assert property (s_dx_start |=> cpu_run_ext_o && dx_cnt == 7'h40)
    else $error("doze extension did not start with 64");
  AST_DX_GATE: assert property (ce_i && dx_state == PMUCC_DX_IDLE && !mwb_ctl_i[3] |=> !cpu_run_ext_o)
    else $error("doze extension without window bit");
  AST_DX_END: assert property (s_dx_last |=> !cpu_run_ext_o)
    else $error("doze extension outlived its 64th refresh");
  AST_TMR_PLAIN: assert property (ce_i && tmr0_irq_i && !tmr_en |=> timer_irq0_o && !mgmt_int_o)
    else $error("timer request not delivered as ordinary interrupt");
  AST_SET_WINS: assert property (ce_i && ev[`PMUCC_S_TMR] |=> stat[`PMUCC_S_TMR])
    else $error("timer event lost against a clear");
  AST_PORT60_ON: assert property (ce_i && kbd_en && io_rd_i && io_adr_i == `PMUCC_KBD_PORT |=> port60_int_o)
    else $error("port read not decoded internally");
  AST_IRQ1_PIN: assert property (ce_i && !kbd_en |=> irq1_o == $past(irq1_s))
    else $error("interrupt 1 not from external pin");
  AST_PLL_DOZE: assert property (ce_i && pmu_mode_i == PMUCC_DOZE |=> hs_pll_stop_o)
    else $error("PLL left running in doze");
  AST_PLL_HS: assert property (ce_i && pmu_mode_i == PMUCC_HS |=> !hs_pll_stop_o)
    else $error("PLL stopped in high-speed mode");
  AST_LS_CLK: assert property (ce_i && ls_entry |=> cpu_clk_o.low_pll && cpu_clk_o.div == $past(clksel[1:0]))
    else $error("low-speed divisor not taken on entry");
  AST_UNIT_SEL: assert property (ce_i |=> {doze_unit_o, ls_unit_o} == $past(unit[7:6]))
    else $error("timer unit selects not following register");
  AST_RST_ZERO: assert property (disable iff (1'b0) rst_i |=> clksel == `PMUCC_RST_CLKSEL && unit == `PMUCC_RST_UNIT)
    else $error("control registers not cleared by reset");
  AST_IRQ_LVL: assert property (ce_i |=> irq_o == |(stat & ien))
    else $error("interrupt level disagrees with enabled status");
  AST_ACK_ONE: assert property (ce_i && ack_o |=> !ack_o)
    else $error("acknowledge longer than one cycle");

endmodule : pmucc_top

// *** tb/pmucc_top_tb.sv ***
// Self-checking bench of the power-management clock control block
`timescale 1ns/10ps
`include "pmucc_regs.svh"
module pmucc_top_tb import pmucc_pkg::*;;
  localparam logic [11:0] A_CLK = {`PMUCC_IDX_CLKSEL, 2'b00};
  localparam logic [11:0] A_RSV = {`PMUCC_IDX_RSVD, 2'b00};
  localparam logic [11:0] A_UNT = {`PMUCC_IDX_UNIT, 2'b00};
  localparam logic [11:0] A_STA = {`PMUCC_IDX_STAT, 2'b00};
  localparam logic [11:0] A_CLR = {`PMUCC_IDX_CLR, 2'b00};
  localparam logic [11:0] A_IEN = {`PMUCC_IDX_IEN, 2'b00};
  logic clk_i = 0, rst_i = 1, ce_i = 1, we_i = 0, cyc_i = 0, stb_i = 0;
  logic tmr0_irq_i = 0, refresh_i = 0, ac_present_input_i = 0, battery_low_1_input_i = 1;
  logic irq1_pin_i = 0, kbd_int_irq_i = 0, kbd_other_ok_i = 0, io_rd_i = 0;
  logic kbd_cs_drv_i = 1, system_clock_pin_drv_i = 1, ext_cs = 1, ext_clk = 0;
  logic [11:0] adr_i = 0;
  logic [31:0] dat_i = 0, dat_o, rnd = 32'hbbc0;
  logic [3:0] sel_i = 0;
  logic [7:0] mwb_ctl_i = 0, act_mask_i = 0, exp_rd;
  logic [15:0] io_adr_i = 0;
  pmucc_mode_t pmu_mode_i = PMUCC_HS;
  pmucc_clk_t cpu_clk_o;
  logic [1:0] pin_sense_o;
  logic ack_o, keyboard_chip_select_pin_o, keyboard_chip_select_pin_oe_o, system_clock_pin_o;
  logic system_clock_pin_oe_o, timer_irq0_o, mgmt_int_o, activity_o, port60_int_o, irq1_o;
  logic hs_pll_stop_o, doze_unit_o, ls_unit_o, cpu_run_ext_o, irq_o;
  // Released pins show what the outside world puts on them
  wire keyboard_chip_select_pin_i = keyboard_chip_select_pin_oe_o ? keyboard_chip_select_pin_o : ext_cs;
  wire system_clock_pin_i = system_clock_pin_oe_o ? system_clock_pin_o : ext_clk;
  int fails = 0, n_checks = 0, n_act = 0;
  logic [7:0] rdq[$];

  pmucc_top pmucc_top_inst (.*);

  always #50 clk_i = ~clk_i;
  // Activity is a one-cycle pulse, so it is counted rather than sampled
  always @(posedge clk_i) if (activity_o === 1'b1) n_act <= n_act + 1;
  // ************
  // Read monitor
  // ************
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      exp_rd = rdq.pop_front();
      n_checks++;
      if (dat_o !== {24'h0, exp_rd}) begin
        $display("Error %0t: read %h expected %h", $time, dat_o, exp_rd);
        fails++;
      end
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    sel_i <= 4'h1;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 0;
    stb_i <= 0;
    we_i <= 0;
  endtask : wb

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    rdq.push_back(e);
    wb(1'b0, a, 8'h00);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      $display("Error %0t: got %h expected %h", $time, g, e);
      fails++;
    end
  endtask : chk

  task automatic pulse();
    @(posedge clk_i);
    refresh_i <= 1;
    @(posedge clk_i);
    refresh_i <= 0;
  endtask : pulse

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  // Whole run is about 380 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    finish_test();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    rd(A_CLK, 8'h00);
    rd(A_UNT, 8'h00);
    rd(A_RSV, `PMUCC_RSVD_VALUE);
    chk({system_clock_pin_oe_o, keyboard_chip_select_pin_oe_o}, 8'h03);
    chk(pin_sense_o, 8'h03);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      wb(1, A_CLK, rnd[7:0]);
      rd(A_CLK, rnd[7:0]);
      wb(1, A_UNT, rnd[15:8]);
      rd(A_UNT, rnd[15:8]);
    end
    wb(1, A_RSV, 8'h5a);
    rd(A_RSV, `PMUCC_RSVD_VALUE);
    rd(12'hffc, 8'h00);
    wb(1, A_CLK, 8'h00);
    wb(1, A_UNT, 8'h00);
    $display("test registers done");
    wb(1, A_CLR, 8'h07);
    wb(1, A_CLK, 8'h40);
    @(posedge clk_i);
    tmr0_irq_i <= 1;
    tick(2);
    chk({mgmt_int_o, timer_irq0_o}, 8'h02);
    @(posedge clk_i);
    tmr0_irq_i <= 0;
    rd(A_STA, 8'h02);
    tick(1);
    chk(irq_o, 8'h00);
    wb(1, A_IEN, 8'h02);
    tick(2);
    chk(irq_o, 8'h01);
    wb(1, A_CLR, 8'h02);
    tick(2);
    chk(irq_o, 8'h00);
    rd(A_STA, 8'h00);
    wb(1, A_CLK, 8'h00);
    @(posedge clk_i);
    tmr0_irq_i <= 1;
    tick(2);
    chk({mgmt_int_o, timer_irq0_o}, 8'h01);
    @(posedge clk_i);
    tmr0_irq_i <= 0;
    $display("test interrupt done");
    for (int s = 0; s < 4; s++) begin
      // Select changed only outside low-speed mode
      wb(1, A_CLK, s[7:0]);
      @(posedge clk_i);
      pmu_mode_i <= PMUCC_LS;
      tick(2);
      chk(cpu_clk_o, {1'b1, s[1:0]});
      chk(hs_pll_stop_o, 8'h00);
      @(posedge clk_i);
      pmu_mode_i <= PMUCC_HS;
      tick(2);
      chk(cpu_clk_o, 8'h00);
    end
    wb(1, A_CLK, 8'h04);
    @(posedge clk_i);
    pmu_mode_i <= PMUCC_LS;
    tick(2);
    chk(hs_pll_stop_o, 8'h01);
    wb(1, A_CLK, 8'h00);
    tick(2);
    chk(hs_pll_stop_o, 8'h00);
    @(posedge clk_i);
    pmu_mode_i <= PMUCC_DOZE;
    tick(2);
    chk(hs_pll_stop_o, 8'h01);
    for (int k = 0; k < 2; k++) begin
      wb(1, A_UNT, 8'h80 >> k);
      tick(2);
      chk({doze_unit_o, ls_unit_o}, 8'h02 >> k);
    end
    $display("test clock done");
    @(posedge clk_i);
    mwb_ctl_i <= 8'h08;
    wb(1, A_UNT, 8'h01);
    @(posedge clk_i);
    tmr0_irq_i <= 1;
    tick(2);
    chk(cpu_run_ext_o, 8'h01);
    repeat (63) pulse();
    tick(1);
    chk(cpu_run_ext_o, 8'h01);
    pulse();
    tick(2);
    chk(cpu_run_ext_o, 8'h00);
    @(posedge clk_i);
    tmr0_irq_i <= 0;
    mwb_ctl_i <= 8'h00;
    repeat (2) @(posedge clk_i);
    tmr0_irq_i <= 1;
    tick(2);
    chk(cpu_run_ext_o, 8'h00);
    @(posedge clk_i);
    tmr0_irq_i <= 0;
    $display("test doze done");
    @(posedge clk_i);
    pmu_mode_i <= PMUCC_HS;
    act_mask_i <= 8'h40;
    wb(1, A_UNT, 8'h20);
    @(posedge clk_i);
    battery_low_1_input_i <= 0;
    tick(5);
    chk(cpu_clk_o, 8'h04);
    @(posedge clk_i);
    ac_present_input_i <= 1;
    tick(5);
    chk(cpu_clk_o, 8'h00);
    chk(n_act[7:0], 8'h00);
    wb(1, A_CLK, 8'h10);
    @(posedge clk_i);
    ac_present_input_i <= 0;
    battery_low_1_input_i <= 1;
    tick(6);
    chk(n_act[7:0], 8'h01);
    rd(A_STA, 8'h05);
    $display("test battery and activity done");
    wb(1, A_CLK, 8'h08);
    @(posedge clk_i);
    kbd_other_ok_i <= 1;
    io_rd_i <= 1;
    io_adr_i <= `PMUCC_KBD_PORT;
    kbd_int_irq_i <= 1;
    ext_cs <= 0;
    ext_clk <= 1;
    tick(6);
    chk({system_clock_pin_oe_o, keyboard_chip_select_pin_oe_o}, 8'h00);
    chk(pin_sense_o, 8'h02);
    chk(port60_int_o, 8'h01);
    chk(irq1_o, 8'h01);
    @(posedge clk_i);
    io_adr_i <= 16'h0061;
    tick(2);
    chk(port60_int_o, 8'h00);
    wb(1, A_CLK, 8'h00);
    tick(6);
    chk(irq1_o, 8'h00);
    chk({system_clock_pin_oe_o, keyboard_chip_select_pin_oe_o}, 8'h03);
    $display("test keyboard done");
    // Clock enable low must freeze the mode change until it returns
    @(posedge clk_i);
    ce_i <= 0;
    pmu_mode_i <= PMUCC_LS;
    tick(3);
    chk(cpu_clk_o, 8'h00);
    @(posedge clk_i);
    ce_i <= 1;
    tick(2);
    chk(cpu_clk_o, 8'h04);
    $display("test clock enable done");
    finish_test();
  end
endmodule : pmucc_top_tb
